// ==== dv/cos_cond_model.sv ====
// Model of the clock conditioner's serial register port.
// Assumes MSB-first data sampled on the rising serial clock and a latch pulse after the last bit.
`default_nettype none
module cos_cond_model (
    // Serial pins
    input  wire logic ser_clk,
    input  wire logic ser_data,
    input  wire logic ser_latch
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Receiver
    // ****************************************************************
    logic [31:0] shift_q;
    logic [31:0] regs [16];
    int          bit_cnt;
    int          last_bits;
    initial begin
        shift_q = 32'h0000_0000;
        bit_cnt = 0;
        last_bits = 0;
    end
    // The latch marks the word boundary, so a short or long frame shows up in last_bits.
    always @(posedge ser_clk or posedge ser_latch) begin
        if (ser_latch) begin
            regs[shift_q[3:0]] = shift_q;
            last_bits = bit_cnt;
            bit_cnt = 0;
        end else begin
            shift_q = {shift_q[30:0], ser_data};
            bit_cnt++;
        end
    end
endmodule : cos_cond_model
`default_nettype wire

// ==== dv/test_cos_top.sv ====
// Self-checking bench for the clock output shadow register block.
// Assumes the package, design sources and conditioner model are compiled first.
`default_nettype none
module test_cos_top
    import cos_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk, reset_n, board_reset_n, sra, sclk, sdata, slatch;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, drive;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic [7:0]  odiv [4];
    logic [3:0]  odly [4];
    logic [1:0]  opath [4];
    int          fails, n_tests;
    cos_top #(.SOFT_RESET_CNT(10)) dut (
        .clk(clk), .reset_n(reset_n), .board_reset_n(board_reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ser_clk(sclk), .ser_data(sdata), .ser_latch(slatch),
        .clk_out_drive(drive), .clk_out_divide(odiv), .clk_out_delay(odly),
        .clk_out_path(opath), .soft_reset_active(sra));
    cos_cond_model cond (.ser_clk(sclk), .ser_data(sdata), .ser_latch(slatch));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic end_sim;
        $display("Mismatches %0d of %0d comparisons", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tmo;
        fails++;
        $display("[FAIL] %0t wait ran out", $time);
        end_sim();
    endtask : tmo
    // Handshakes are sampled at the falling edge, where the slave's outputs have settled.
    task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic ta, tw, tb;
        r = 2'h3;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                return;
            end
        end
        tmo();
    endtask : axw
    task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                return;
            end
        end
        tmo();
    endtask : axr
    task automatic wait_idle;
        logic [31:0] d;
        logic [1:0]  r;
        for (int n = 0; n < 200; n++) begin
            axr(CSR_OFFSET, d, r);
            if (d[CSR_BUSY_BIT] === 1'b0) return;
        end
        tmo();
    endtask : wait_idle
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        logic [15:0] off [4];
        logic [3:0]  code [4];
        logic [7:0]  dv [4];
        logic [3:0]  dl [4];
        logic [31:0] expv [4];
        logic [31:0] v, d;
        logic [1:0]  r;
        int          k;
        off = '{LOGIC_CLK_OFFSET, GP_CLK_OFFSET, ADC1_CLK_OFFSET, ADC2_CLK_OFFSET};
        code = '{ADDR_CODE_LOGIC, ADDR_CODE_GP, ADDR_CODE_ADC1, ADDR_CODE_ADC2};
        dv = '{8'hFF, 8'h01, 8'h80, 8'h7F};
        dl = '{4'hF, 4'h0, 4'h5, 4'hA};
        {fails, n_tests} = {32'd0, 32'd0};
        {reset_n, board_reset_n, awvalid, wvalid, bready, arvalid, rready} = 7'b0100000;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            axr(off[i], d, r);
            cmp(d, CTRL_RESET | 32'(code[i]));
        end
        axr(CSR_OFFSET, d, r);
        cmp(d, 32'h0000_0000);
        // Each register gets its own path code and a boundary divider value.
        for (int i = 0; i < 4; i++) begin
            v = {13'h0000, 2'(i), 1'b1, dv[i], dl[i], 4'hF};
            expv[i] = (v & CTRL_WRITE_MASK) | 32'(code[i]);
            axw(off[i], v, 4'hF, r);
            cmp(32'(r), 32'h0);
            axr(CSR_OFFSET, d, r);
            cmp(32'(d[CSR_BUSY_BIT]), 32'h1);
            wait_idle();
            axr(off[i], d, r);
            cmp(d, expv[i]);
            cmp(cond.regs[code[i]], expv[i]);
            cmp(32'(cond.last_bits), 32'd32);
            cmp(32'(opath[i]), 32'(i));
            cmp(32'(odiv[i]), 32'(dv[i]));
            cmp(32'(odly[i]), 32'(dl[i]));
            cmp(32'(drive), 32'h0);
        end
        axw(CSR_OFFSET, 32'h0000_0010, 4'hF, r);
        @(negedge clk);
        cmp(32'(drive), 32'hF);
        axw(ADC2_CLK_OFFSET, 32'h0000_0000, 4'hF, r);
        wait_idle();
        cmp(32'(drive), 32'h7);
        axw(GP_CLK_OFFSET, 32'h0001_0200, 4'hF, r);
        axw(GP_CLK_OFFSET, 32'h0001_0400, 4'hF, r);
        cmp(32'(r), 32'h2);
        wait_idle();
        axr(GP_CLK_OFFSET, d, r);
        cmp(d, 32'h0001_0201);
        axw(ADC1_CLK_OFFSET, 32'h0000_0000, 4'h3, r);
        cmp(32'(r), 32'h2);
        axr(ADC1_CLK_OFFSET, d, r);
        cmp(d, expv[2]);
        axr(16'h8200, d, r);
        cmp(32'(r), 32'h2);
        cmp(d, 32'h0000_0000);
        board_reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        board_reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        axr(LOGIC_CLK_OFFSET, d, r);
        cmp(d, expv[0]);
        axw(LOGIC_CLK_OFFSET, 32'h8000_0000, 4'hF, r);
        k = 0;
        repeat (50) begin
            @(negedge clk);
            if (sra === 1'b1) k++;
        end
        cmp(32'(k > 0 && k <= 12), 32'h1);
        for (int i = 0; i < 4; i++) begin
            axr(off[i], d, r);
            cmp(d, CTRL_RESET | 32'(code[i]));
        end
        cmp(32'(drive), 32'h0);
        end_sim();
    end
endmodule : test_cos_top
`default_nettype wire

// ==== src/cos_pkg.sv ====
// Package for the clock output shadow register block.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
`default_nettype none
package cos_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [15:0] CSR_OFFSET         = 16'h8110;
    localparam logic [15:0] LOGIC_CLK_OFFSET   = 16'h8114;
    localparam logic [15:0] GP_CLK_OFFSET      = 16'h8118;
    localparam logic [15:0] ADC1_CLK_OFFSET    = 16'h811C;
    localparam logic [15:0] ADC2_CLK_OFFSET    = 16'h8120;
    localparam logic [15:0] ADDR_MASK          = 16'hFFFF;
    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int ADDR_CODE_LSB     = 0;
    localparam int DELAY_LSB         = 4;
    localparam int DIVIDE_LSB        = 8;
    localparam int LOCAL_EN_BIT      = 16;
    localparam int PATH_LSB          = 17;
    localparam int SOFT_RESET_BIT    = 31;
    localparam int CSR_BUSY_BIT      = 0;
    localparam int CSR_GLOBAL_EN_BIT = 4;
    localparam logic [31:0] CTRL_WRITE_MASK = 32'h0007_FFF0;
    // ****************************************************************
    // Reset values and fixed codes
    // ****************************************************************
    localparam logic [3:0]  ADDR_CODE_LOGIC = 4'h0;
    localparam logic [3:0]  ADDR_CODE_GP    = 4'h1;
    localparam logic [3:0]  ADDR_CODE_ADC1  = 4'h3;
    localparam logic [3:0]  ADDR_CODE_ADC2  = 4'h4;
    localparam logic [7:0]  DIVIDE_RESET    = 8'h01;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0100;
    // ****************************************************************
    // Path select codes
    // ****************************************************************
    localparam logic [1:0] PATH_BYPASS  = 2'h0;
    localparam logic [1:0] PATH_DIVIDE  = 2'h1;
    localparam logic [1:0] PATH_DELAY   = 2'h2;
    localparam logic [1:0] PATH_BOTH    = 2'h3;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ           = 100;
    localparam int SOFT_RESET_US     = 10;
    localparam int SOFT_RESET_CYCLES = SOFT_RESET_US * CLK_MHZ;
    localparam int SER_DIV           = 4;
    localparam int SER_BITS          = 32;
    localparam int DELAY_STEP_PS     = 150;
    localparam int DELAY_BASE_PS     = 400;
    function automatic logic [3:0] cos_addr_code(input logic [1:0] idx);
        case (idx)
            2'h0:    cos_addr_code = ADDR_CODE_LOGIC;
            2'h1:    cos_addr_code = ADDR_CODE_GP;
            2'h2:    cos_addr_code = ADDR_CODE_ADC1;
            default: cos_addr_code = ADDR_CODE_ADC2;
        endcase
    endfunction : cos_addr_code
endpackage : cos_pkg
`default_nettype wire

// ==== src/cos_ser_if.sv ====
// Interface between register block and serial shifter.
// Assumes both ends share one clock.
`default_nettype none
interface cos_ser_if;
    logic        start;
    logic [31:0] word;
    logic        busy;
    modport regs  (output start, output word, input busy);
    modport shift (input start, input word, output busy);
endinterface : cos_ser_if
`default_nettype wire

// ==== src/cos_ser_shift.sv ====
// Serial shifter that loads one 32-bit word into the clock conditioner.
// Assumes start is only raised while busy is low.
`default_nettype none
module cos_ser_shift
    import cos_pkg::*;
#(
    parameter int DIV = SER_DIV
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    cos_ser_if.shift  ctl,
    // Serial pins
    output var logic  ser_clk,
    output var logic  ser_data,
    output var logic  ser_latch
);
    initial begin
        if (DIV < 2) $error("DIV must be at least 2");
    end
    typedef enum logic [1:0] {
        SH_IDLE  = 2'b00,
        SH_SHIFT = 2'b01,
        SH_LATCH = 2'b10
    } cos_sh_state_type;
    typedef struct packed {
        cos_sh_state_type st;
        logic [31:0]      sr;
        logic [5:0]       bits;
        logic [7:0]       div;
        logic             sclk;
        logic             latch;
    } cos_sh_type;
    cos_sh_type s_q, s_d;
    always_comb begin
        s_d = s_q;
        case (s_q.st)
            SH_IDLE: begin
                s_d.latch = 1'b0;
                if (ctl.start) begin
                    s_d.st   = SH_SHIFT;
                    s_d.sr   = ctl.word;
                    s_d.bits = 6'h00;
                    s_d.div  = 8'h00;
                end
            end
            SH_SHIFT: begin
                s_d.div = s_q.div + 8'h01;
                if (s_q.div == 8'(DIV - 1)) begin
                    s_d.div  = 8'h00;
                    s_d.sclk = ~s_q.sclk;
                    if (s_q.sclk) begin
                        s_d.sr   = {s_q.sr[30:0], 1'b0};
                        s_d.bits = s_q.bits + 6'h01;
                        if (s_q.bits == 6'(SER_BITS - 1)) begin
                            s_d.st = SH_LATCH;
                        end
                    end
                end
            end
            SH_LATCH: begin
                s_d.latch = 1'b1;
                s_d.div   = s_q.div + 8'h01;
                if (s_q.div == 8'(DIV - 1)) begin
                    s_d.st = SH_IDLE;
                end
            end
            default: s_d.st = SH_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // Busy stays high until the last cycle of the latch pulse; ser_latch drops one cycle after busy falls.
    assign ctl.busy  = (s_q.st != SH_IDLE); // R19
    assign ser_clk   = s_q.sclk;
    assign ser_data  = s_q.sr[31];
    assign ser_latch = s_q.latch;
    AST_LATCH_ENDS_BUSY: assert property (@(posedge clk) disable iff (!rst_n) // R19
        $fell(ctl.busy) |-> $past(s_q.latch))
        else $error("busy fell without latch");
endmodule : cos_ser_shift
`default_nettype wire

// ==== src/cos_top.sv ====
// Top of the clock output shadow register block.
// Assumes an AXI4-Lite master with 32-bit data and one 100 MHz clock.
//
// The implementer's own choice: register access over AXI4-Lite.
`default_nettype none

// Summary of operation
// (R01) Four control registers at 8114h-8120h.
// (R02) Low nibble holds fixed address code.
// (R03) Bits 7-4 select output delay.
// (R04) Bits 15-8 divider code, reset 01h.
// (R05) Bit 16 enables its own output.
// (R06) Output needs local and global enable.
// (R07) Bits 18-17 pick divide or delay.
// (R08) Board reset leaves registers unchanged.
// (R09) Power-up or bit 31 resets them.
// (R10) Reset clears all but documented defaults.
// (R11) Only full 32-bit accesses are accepted.
// (R12) Each accepted control-register write, except a bit-31 soft reset, is shifted to conditioner.
// (R13) Busy shown at CSR bit 0.
// (R14) Host waits for busy before writing.
// (R15) Path codes bypass, divide, delay, both.
// (R16) Bit 31 self-clears, reset up to 10us.
// (R17) CSR bit 4 is global output enable.
// (R18) Busy high during whole serial programming.
// (R19) Busy rises at write, falls after latch.
// (R20) Reads return shadow with address code.
module cos_top
    import cos_pkg::*;
#(
    parameter int SOFT_RESET_CNT = SOFT_RESET_CYCLES
) (
    // Clock and resets
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        board_reset_n,

    // AXI4-Lite write address
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var logic         s_axi_awready,

    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var logic         s_axi_wready,

    // AXI4-Lite write response
    output var logic [1:0]   s_axi_bresp,
    output var logic         s_axi_bvalid,
    input  wire logic        s_axi_bready,

    // AXI4-Lite read address
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var logic         s_axi_arready,

    // AXI4-Lite read data
    output var logic [31:0]  s_axi_rdata,
    output var logic [1:0]   s_axi_rresp,
    output var logic         s_axi_rvalid,
    input  wire logic        s_axi_rready,

    // Conditioner serial pins
    output var logic         ser_clk,
    output var logic         ser_data,
    output var logic         ser_latch,

    // Decoded output controls
    output var logic [3:0]   clk_out_drive,
    output var logic [7:0]   clk_out_divide [4],
    output var logic [3:0]   clk_out_delay [4],
    output var logic [1:0]   clk_out_path [4],
    output var logic         soft_reset_active
);

    initial begin
        if (SOFT_RESET_CNT < 1 || SOFT_RESET_CNT > 65535) $error("SOFT_RESET_CNT out of range");
    end

    // ****************************************************************
    // Reset synchroniser
    // ****************************************************************
    logic [1:0] rst_sync_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    logic rst_n;
    assign rst_n = rst_sync_q[1];

    // Board reset is only synchronised; the shadow registers ignore it.
    // Its idle level is high, so the synchroniser resets high to show no false board reset.
    logic [1:0] brd_sync_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brd_sync_q <= 2'h3;
        end else begin
            brd_sync_q <= {brd_sync_q[0], board_reset_n};
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [3:0][31:0] ctrl;
        logic             global_en;
        logic             aw_got;
        logic             w_got;
        logic [15:0]      awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic             start;
        logic [31:0]      word;
        logic [15:0]      srst_cnt;
    } cos_state_type;

    cos_state_type r_q, r_d;
    cos_ser_if ser ();

    function automatic logic [2:0] cos_decode(input logic [15:0] a);
        case (a & ADDR_MASK) // R01
            LOGIC_CLK_OFFSET: cos_decode = 3'h0;
            GP_CLK_OFFSET:    cos_decode = 3'h1;
            ADC1_CLK_OFFSET:  cos_decode = 3'h2;
            ADC2_CLK_OFFSET:  cos_decode = 3'h3;
            CSR_OFFSET:       cos_decode = 3'h4;
            default:          cos_decode = 3'h7;
        endcase
    endfunction : cos_decode

    function automatic logic [31:0] cos_ctrl_reset(input logic [1:0] idx);
        cos_ctrl_reset = CTRL_RESET | {28'h0, cos_addr_code(idx)};
    endfunction : cos_ctrl_reset

    logic        busy;
    logic [2:0]  wsel;
    logic [2:0]  rsel;
    logic        wr_fire;
    logic [31:0] csr_rd;

    assign busy   = ser.busy | r_q.start | (r_q.srst_cnt != 16'h0000); // R18
    assign wsel   = cos_decode(r_q.awaddr);
    assign rsel   = cos_decode(s_axi_araddr);
    assign csr_rd = {27'h0, r_q.global_en, 3'h0, busy}; // R13 R17
    assign wr_fire = r_q.aw_got & r_q.w_got & ~r_q.bvalid;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        r_d       = r_q;
        r_d.start = 1'b0;
        if (r_q.srst_cnt != 16'h0000) begin
            r_d.srst_cnt = r_q.srst_cnt - 16'h0001;
        end

        if (s_axi_awvalid & s_axi_awready) begin
            r_d.aw_got = 1'b1;
            r_d.awaddr = s_axi_awaddr;
        end

        if (s_axi_wvalid & s_axi_wready) begin
            r_d.w_got = 1'b1;
            r_d.wdata = s_axi_wdata;
            r_d.wstrb = s_axi_wstrb;
        end

        if (wr_fire) begin
            r_d.aw_got = 1'b0;
            r_d.w_got  = 1'b0;
            r_d.bvalid = 1'b1;
            r_d.bresp  = 2'h0;
            if (wsel == 3'h7 || r_q.wstrb != 4'hF) begin
                r_d.bresp = 2'h2; // R11
            end else if (wsel == 3'h4) begin
                r_d.global_en = r_q.wdata[CSR_GLOBAL_EN_BIT]; // R17
            end else if (wsel == 3'h0 && r_q.wdata[SOFT_RESET_BIT]) begin
                // Soft reset restores every shadow and the bit reads back as zero.
                for (int i = 0; i < 4; i++) begin
                    r_d.ctrl[i] = cos_ctrl_reset(2'(i)); // R09 R10 R16
                end
                r_d.srst_cnt = 16'(SOFT_RESET_CNT); // R16
            end else if (!busy) begin
                r_d.ctrl[wsel[1:0]] = (r_q.wdata & CTRL_WRITE_MASK) | {28'h0, cos_addr_code(wsel[1:0])}; // R02 R20
                r_d.start = 1'b1; // R12 R19
                r_d.word  = r_d.ctrl[wsel[1:0]];
            end else begin
                // A write during programming would corrupt the shifted word.
                r_d.bresp = 2'h2; // R14
            end
        end

        if (r_q.bvalid & s_axi_bready) begin
            r_d.bvalid = 1'b0;
        end

        if (s_axi_arvalid & s_axi_arready) begin
            r_d.rvalid = 1'b1;
            r_d.rresp  = 2'h0;
            case (rsel)
                3'h4:    r_d.rdata = csr_rd;
                3'h7: begin
                    r_d.rdata = 32'h0000_0000;
                    r_d.rresp = 2'h2;
                end
                default: r_d.rdata = r_q.ctrl[rsel[1:0]]; // R20
            endcase
        end

        if (r_q.rvalid & s_axi_rready) begin
            r_d.rvalid = 1'b0;
        end
    end

    // Only power-up reset reaches this register; board reset does not.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q          <= '0;
            r_q.ctrl[0]  <= {CTRL_RESET[31:4], ADDR_CODE_LOGIC}; // R08 R09 R10
            r_q.ctrl[1]  <= {CTRL_RESET[31:4], ADDR_CODE_GP};
            r_q.ctrl[2]  <= {CTRL_RESET[31:4], ADDR_CODE_ADC1};
            r_q.ctrl[3]  <= {CTRL_RESET[31:4], ADDR_CODE_ADC2};
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Serial shifter
    // ****************************************************************
    assign ser.start = r_q.start;
    assign ser.word  = r_q.word;
    cos_ser_shift #(.DIV(SER_DIV)) u_shift (
        .clk       (clk),
        .rst_n     (rst_n),
        .ctl       (ser),
        .ser_clk   (ser_clk),
        .ser_data  (ser_data),
        .ser_latch (ser_latch)
    );

    // ****************************************************************
    // Bus outputs
    // ****************************************************************
    assign s_axi_awready = ~r_q.aw_got & ~r_q.bvalid;
    assign s_axi_wready  = ~r_q.w_got & ~r_q.bvalid;
    assign s_axi_bvalid  = r_q.bvalid;
    assign s_axi_bresp   = r_q.bresp;
    assign s_axi_arready = ~r_q.rvalid;
    assign s_axi_rvalid  = r_q.rvalid;
    assign s_axi_rdata   = r_q.rdata;
    assign s_axi_rresp   = r_q.rresp;
    assign soft_reset_active = (r_q.srst_cnt != 16'h0000);

    // ****************************************************************
    // Output controls
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            clk_out_drive[i]  = r_q.ctrl[i][LOCAL_EN_BIT] & r_q.global_en; // R05 R06
            clk_out_divide[i] = r_q.ctrl[i][DIVIDE_LSB +: 8]; // R04
            clk_out_delay[i]  = r_q.ctrl[i][DELAY_LSB +: 4]; // R03
            clk_out_path[i]   = r_q.ctrl[i][PATH_LSB +: 2]; // R07 R15
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence write_accepted;
        wr_fire && wsel < 3'h4 && r_q.wstrb == 4'hF && !busy && !r_q.wdata[SOFT_RESET_BIT];
    endsequence

    // A refused write must leave the shifter alone, or the word in flight would be torn.
    sequence ctrl_write_while_busy;
        wr_fire && wsel < 3'h4 && r_q.wstrb == 4'hF && busy && !(wsel == 3'h0 && r_q.wdata[SOFT_RESET_BIT]);
    endsequence

    AST_BUSY_ON_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R19
        write_accepted |=> busy)
        else $error("busy not set on write");

    AST_SHIFT_STARTS: assert property (@(posedge clk) disable iff (!rst_n) // R12
        write_accepted |=> r_q.start ##1 ser.busy)
        else $error("serial transfer did not start");

    AST_ADDR_CODE: assert property (@(posedge clk) disable iff (!rst_n) // R02
        r_q.ctrl[2][3:0] == ADDR_CODE_ADC1 && r_q.ctrl[3][3:0] == ADDR_CODE_ADC2)
        else $error("address code lost");

    AST_ADDR_CODE_LOW: assert property (@(posedge clk) disable iff (!rst_n) // R02
        r_q.ctrl[0][3:0] == ADDR_CODE_LOGIC && r_q.ctrl[1][3:0] == ADDR_CODE_GP)
        else $error("low address code lost");

    AST_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // R06
        clk_out_drive[1] == (r_q.global_en && r_q.ctrl[1][LOCAL_EN_BIT]))
        else $error("drive mismatch");

    AST_GLOBAL_OFF: assert property (@(posedge clk) disable iff (!rst_n) // R17
        !r_q.global_en |-> clk_out_drive == 4'h0)
        else $error("output driven while globally disabled");

    AST_SRST_CLEARS: assert property (@(posedge clk) disable iff (!rst_n) // R16
        $rose(soft_reset_active) |-> r_q.ctrl[0][SOFT_RESET_BIT] == 1'b0 && r_q.ctrl[0][15:8] == DIVIDE_RESET)
        else $error("soft reset bad");

    AST_SRST_BUSY: assert property (@(posedge clk) disable iff (!rst_n) // R16 R18
        soft_reset_active |-> busy && !r_q.start)
        else $error("soft reset not busy");

    AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (r_q.ctrl[0][31:19] | r_q.ctrl[1][31:19] | r_q.ctrl[2][31:19] | r_q.ctrl[3][31:19]) == 13'h0000)
        else $error("unused shadow bits set");

    AST_NARROW_ERR: assert property (@(posedge clk) disable iff (!rst_n) // R11
        wr_fire && r_q.wstrb != 4'hF |=> s_axi_bresp == 2'h2)
        else $error("narrow write accepted");

    AST_BUSY_REFUSES: assert property (@(posedge clk) disable iff (!rst_n) // R14
        ctrl_write_while_busy |=> s_axi_bresp == 2'h2 && !r_q.start)
        else $error("write during busy accepted");

    AST_CSR_BUSY: assert property (@(posedge clk) disable iff (!rst_n) // R13
        s_axi_arvalid && s_axi_arready && rsel == 3'h4 |=> s_axi_rdata[0] == $past(busy))
        else $error("csr busy");

    AST_READBACK: assert property (@(posedge clk) disable iff (!rst_n) // R20
        s_axi_arvalid && s_axi_arready && rsel == 3'h0 |=> s_axi_rdata == $past(r_q.ctrl[0]))
        else $error("readback");

    // Board reset must never reach a shadow register.
    AST_BOARD_RESET_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) // R08
        !brd_sync_q[1] && !wr_fire |=> $stable(r_q.ctrl))
        else $error("board reset moved a shadow");

endmodule : cos_top
`default_nettype wire
